// ===== adrg_cfg.svh
// Behaviour
// - Select codes 011 to 111 pick registers
// - Result register is read-only, 24 bits
// - Finished result read sets ready flag high
// - Append status byte after result when enabled
// - Status low nibble carries result channel code
// - Channel codes 0-7, temp 1000, short 1001
// - Identity register read-only, fixed low nibble
// - Bit 6 closes bridge switch to ground
// - Bridge switch keeps state in power-down
// - Bit 5 enables output pins 3 and 2
// - Bit 4 enables output pins 1 and 0
// - Enabled data bits drive matching pins
// - Read returns pin level for enabled bits
// - Pins 1,0 become reference when selected
// - Five offset registers; pseudo mode shares one
// - Pseudo channels 4-7 use pair 4; short pair 0
// - Active channel's coefficient pair is used
// - Offset resets 0x800000; calibration overwrites
// - Full-scale loads factory value at power-on
`ifndef ADRG_CFG_SVH
`define ADRG_CFG_SVH
// Register select codes
`define ADRG_SEL_RESULT 3'h3
`define ADRG_SEL_ID 3'h4
`define ADRG_SEL_GPO 3'h5
`define ADRG_SEL_OFFSET 3'h6
`define ADRG_SEL_FS 3'h7
// Reset values
`define ADRG_RESULT_RST 24'h000000
`define ADRG_GPO_RST 8'h00
`define ADRG_OFFSET_RST 24'h800000
`define ADRG_FS_RST 24'h000000
// Output port control fields
`define ADRG_GPO_BRIDGE 6
`define ADRG_GPO_UPPER_EN 5
`define ADRG_GPO_LOWER_EN 4
// Command byte fields
`define ADRG_CMD_RD 6
`define ADRG_CMD_SEL_HI 5
`define ADRG_CMD_SEL_LO 3
// Transfer lengths in link clock edges
`define ADRG_CMD_LEN 6'h08
`define ADRG_LEN_BYTE 6'h08
`define ADRG_LEN_WORD 6'h18
`define ADRG_LEN_APPEND 6'h20
// Channel codes and pairs
`define ADRG_CHAN_TEMP 4'h8
`define ADRG_CHAN_SHORT 4'h9
`define ADRG_SHARED_PAIR 3'h4
`define ADRG_SHORT_PAIR 3'h0
`define ADRG_PAIRS 5
`endif

// ===== adrg_pkg.sv
package adrg_pkg;
  // Serial frame phases
  typedef enum logic [1:0] {LNK_CMD, LNK_DATA, LNK_DONE} adrg_link_state_type;
  // New conversion from the filter
  typedef struct packed {
    logic valid;
    logic [23:0] data;
    logic [3:0] chan;
  } adrg_conv_type;
  // Calibration engine result
  typedef struct packed {
    logic offset_we;
    logic fs_we;
    logic [23:0] value;
  } adrg_cal_type;
  // Host write handed from the link
  typedef struct packed {
    logic [2:0] sel;
    logic [23:0] data;
  } adrg_write_type;
  // Read image frozen during frames
  typedef struct packed {
    logic [23:0] result;
    logic [7:0] status;
    logic [7:0] id;
    logic [7:0] gpo;
    logic [23:0] offset;
    logic [23:0] fs;
    logic append;
  } adrg_snap_type;
  // Five coefficient words
  typedef logic [4:0][23:0] adrg_coef_bank_type;
endpackage

// ===== adrg_regs.sv
`timescale 1ns/1ps
`include "adrg_cfg.svh"
module adrg_regs #(
  parameter logic [3:0] PART_ID_NIBBLE = 4'h5 // Arbitrary identity value
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic link_cs_n,
  input wire logic link_din,
  output logic link_dout,
  output logic link_dout_oe,
  input wire adrg_pkg::adrg_conv_type conv,
  input wire logic [2:0] status_flags,
  input wire logic append_status_enable,
  input wire logic pseudo_diff,
  input wire logic reference_select,
  input wire logic [3:0] active_channel,
  input wire adrg_pkg::adrg_cal_type cal,
  input wire adrg_pkg::adrg_coef_bank_type factory_full_scale,
  input wire logic [3:0] gpo_pin_level,
  output logic ready_n,
  output logic [3:0] gpo_out,
  output logic [3:0] gpo_oe,
  output logic bridge_switch_ctrl,
  output logic [23:0] active_offset,
  output logic [23:0] active_full_scale
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Link side
  logic link_frame_rst; // Frame end or reset
  adrg_pkg::adrg_link_state_type lnk_state_ff; // Frame phase
  logic [5:0] cnt_ff; // Edge counter in phase
  logic [6:0] cmd_ff; // Command bits so far
  logic [31:0] shift_ff; // Data shifter
  logic [5:0] len_ff; // Data length
  logic rd_ff; // Frame is a read
  logic [2:0] sel_ff; // Register select
  logic dout_ff; // Serial out bit
  logic dout_oe_ff; // Serial out enable
  logic [7:0] cmd_new; // Completed command byte
  logic [2:0] nxt_sel; // Decoded select
  logic nxt_rd; // Decoded direction
  logic [31:0] img; // Read image aligned high
  logic [5:0] nxt_len; // Data length for command
  logic last_bit; // Final data edge
  logic wr_tgl_ff; // Write event toggle
  logic rd_tgl_ff; // Result read done toggle
  adrg_pkg::adrg_write_type wr_word_ff; // Word to write

  // System side
  logic cs_s1_ff; // Frame sync stage 1
  logic cs_s2_ff; // Frame sync stage 2
  logic [2:0] wt_sync_ff; // Write toggle sync
  logic [2:0] rt_sync_ff; // Read toggle sync
  logic wr_evt; // Host write arrived
  logic rd_evt; // Result read completed
  logic [3:0] pin_s1_ff; // Pin sync stage 1
  logic [3:0] pin_s2_ff; // Pin sync stage 2
  logic [23:0] result_ff; // Conversion result
  logic [3:0] result_chan_ff; // Channel of result
  logic ready_n_ff; // Ready flag, low active
  logic [7:0] gpo_ctrl_ff; // Output port control
  logic [4:0][23:0] offset_ff; // Offset coefficients
  adrg_pkg::adrg_coef_bank_type fs_ff; // Full-scale coefficients
  logic fs_loaded_ff; // Factory values taken
  logic [2:0] pair; // Active pair index
  logic [7:0] gpo_read; // Port control read view
  adrg_pkg::adrg_snap_type snap_ff; // Frozen read image
  logic [3:0] gpo_out_ff; // Pin drive levels
  logic [3:0] gpo_oe_ff; // Pin drive enables
  logic bridge_ff; // Bridge switch drive
  logic [23:0] act_off_ff; // Active offset out
  logic [23:0] act_fs_ff; // Active full-scale out

  ////////////////////////////////////////////////////////////////////////////
  // Channel to calibration pair

  function automatic logic [2:0] pair_of(input logic [3:0] chan, input logic pseudo);
    logic [2:0] p;
    p = {1'b0, chan[1:0]};
    if (chan == `ADRG_CHAN_SHORT)
      p = `ADRG_SHORT_PAIR;
    else if (chan[3])
      p = `ADRG_SHORT_PAIR; // Temperature has no pair of its own
    else if (pseudo && chan[2])
      p = `ADRG_SHARED_PAIR;
    else if (pseudo)
      p = chan[2:0];
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain

  // Frame logic is held idle while the frame is off
  assign link_frame_rst = rst | link_cs_n;

  // Command decode from the byte being completed
  assign cmd_new = {cmd_ff, link_din};
  assign nxt_sel = cmd_new[`ADRG_CMD_SEL_HI:`ADRG_CMD_SEL_LO];
  assign nxt_rd = cmd_new[`ADRG_CMD_RD];
  assign last_bit = (lnk_state_ff == adrg_pkg::LNK_DATA) && (cnt_ff == len_ff - 6'h01);

  // Read image and length per register
  always_comb
  begin
    img = 32'h00000000;
    nxt_len = `ADRG_LEN_BYTE;
    case (nxt_sel)
      `ADRG_SEL_RESULT:
      begin
        nxt_len = `ADRG_LEN_WORD;
        img = {snap_ff.result, 8'h00};
        if (nxt_rd && snap_ff.append)
        begin
          nxt_len = `ADRG_LEN_APPEND;
          img = {snap_ff.result, snap_ff.status};
        end
      end
      `ADRG_SEL_ID: img = {snap_ff.id, 24'h000000};
      `ADRG_SEL_GPO: img = {snap_ff.gpo, 24'h000000};
      `ADRG_SEL_OFFSET:
      begin
        nxt_len = `ADRG_LEN_WORD;
        img = {snap_ff.offset, 8'h00};
      end
      `ADRG_SEL_FS:
      begin
        nxt_len = `ADRG_LEN_WORD;
        img = {snap_ff.fs, 8'h00};
      end
      default: img = 32'h00000000; // Other registers read zero
    endcase
  end

  // Serial shifter, most significant bit first
  always_ff @(posedge link_clk or posedge link_frame_rst)
  begin
    if (link_frame_rst)
    begin
      lnk_state_ff <= adrg_pkg::LNK_CMD;
      cnt_ff <= 6'h00;
      cmd_ff <= 7'h00;
      shift_ff <= 32'h00000000;
      len_ff <= 6'h00;
      rd_ff <= 1'b0;
      sel_ff <= 3'h0;
      dout_ff <= 1'b0;
      dout_oe_ff <= 1'b0;
    end
    else
    begin
      case (lnk_state_ff)
        // Collect the command byte
        adrg_pkg::LNK_CMD:
        begin
          cmd_ff <= cmd_new[6:0];
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == `ADRG_CMD_LEN - 6'h01)
          begin
            lnk_state_ff <= adrg_pkg::LNK_DATA;
            cnt_ff <= 6'h00;
            sel_ff <= nxt_sel;
            rd_ff <= nxt_rd;
            len_ff <= nxt_len;
            shift_ff <= img;
            dout_ff <= nxt_rd & img[31];
            dout_oe_ff <= nxt_rd;
          end
        end
        // Shift data both ways
        adrg_pkg::LNK_DATA:
        begin
          shift_ff <= {shift_ff[30:0], link_din};
          dout_ff <= rd_ff & shift_ff[30];
          cnt_ff <= cnt_ff + 6'h01;
          if (last_bit)
          begin
            lnk_state_ff <= adrg_pkg::LNK_DONE;
            dout_oe_ff <= 1'b0;
          end
        end
        // Further edges ignored until frame ends
        adrg_pkg::LNK_DONE: dout_oe_ff <= 1'b0;
        default: lnk_state_ff <= adrg_pkg::LNK_CMD;
      endcase
    end
  end

  // Completion events toward the system clock
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_tgl_ff <= 1'b0;
      rd_tgl_ff <= 1'b0;
      wr_word_ff <= '0;
    end
    else if (last_bit)
    begin
      if (!rd_ff)
      begin
        wr_word_ff <= '{sel: sel_ff, data: {shift_ff[22:0], link_din}};
        wr_tgl_ff <= ~wr_tgl_ff;
      end
      else if (sel_ff == `ADRG_SEL_RESULT)
        rd_tgl_ff <= ~rd_tgl_ff;
    end
  end

  assign link_dout = dout_ff;
  assign link_dout_oe = dout_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // System domain crossings

  // Frame level, pin levels and event toggles
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      wt_sync_ff <= 3'h0;
      rt_sync_ff <= 3'h0;
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
    end
    else if (ce)
    begin
      cs_s1_ff <= link_cs_n;
      cs_s2_ff <= cs_s1_ff;
      wt_sync_ff <= {wt_sync_ff[1:0], wr_tgl_ff};
      rt_sync_ff <= {rt_sync_ff[1:0], rd_tgl_ff};
      pin_s1_ff <= gpo_pin_level;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Edges seen past the first sync stage only
  assign wr_evt = ce & (wt_sync_ff[2] ^ wt_sync_ff[1]);
  assign rd_evt = ce & (rt_sync_ff[2] ^ rt_sync_ff[1]);

  ////////////////////////////////////////////////////////////////////////////
  // Result and ready flag

  // Result only changes on a new conversion
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      result_ff <= `ADRG_RESULT_RST;
      result_chan_ff <= 4'h0;
    end
    else if (ce && conv.valid)
    begin
      result_ff <= conv.data;
      result_chan_ff <= conv.chan;
    end
  end

  // New result beats a read completing the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ready_n_ff <= 1'b1;
    else if (ce && conv.valid)
      ready_n_ff <= 1'b0;
    else if (rd_evt)
      ready_n_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output port control

  // Host writes to port control
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      gpo_ctrl_ff <= `ADRG_GPO_RST;
    else if (wr_evt && wr_word_ff.sel == `ADRG_SEL_GPO)
      gpo_ctrl_ff <= wr_word_ff.data[7:0];
  end

  // Pin drive; disabled pairs tristate and drive low
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      gpo_oe_ff <= 4'h0;
      gpo_out_ff <= 4'h0;
      bridge_ff <= 1'b0;
    end
    else if (ce)
    begin
      gpo_oe_ff[3:2] <= {2{gpo_ctrl_ff[`ADRG_GPO_UPPER_EN]}};
      gpo_oe_ff[1:0] <= {2{gpo_ctrl_ff[`ADRG_GPO_LOWER_EN] & ~reference_select}};
      gpo_out_ff[3:2] <= gpo_ctrl_ff[3:2] & {2{gpo_ctrl_ff[`ADRG_GPO_UPPER_EN]}};
      gpo_out_ff[1:0] <= gpo_ctrl_ff[1:0]
        & {2{gpo_ctrl_ff[`ADRG_GPO_LOWER_EN] & ~reference_select}};
      bridge_ff <= gpo_ctrl_ff[`ADRG_GPO_BRIDGE];
    end
  end

  // Enabled data bits read back the pin level
  always_comb
  begin
    gpo_read = gpo_ctrl_ff;
    if (gpo_ctrl_ff[`ADRG_GPO_UPPER_EN])
      gpo_read[3:2] = pin_s2_ff[3:2];
    if (gpo_ctrl_ff[`ADRG_GPO_LOWER_EN])
      gpo_read[1:0] = pin_s2_ff[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration coefficients

  assign pair = pair_of(active_channel, pseudo_diff);

  // Offsets; calibration wins over a host write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      offset_ff <= {`ADRG_PAIRS{`ADRG_OFFSET_RST}};
    else if (ce && cal.offset_we)
      offset_ff[pair] <= cal.value;
    else if (wr_evt && wr_word_ff.sel == `ADRG_SEL_OFFSET)
      offset_ff[pair] <= wr_word_ff.data;
  end

  // Full-scale; factory load right after reset release
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fs_ff <= {`ADRG_PAIRS{`ADRG_FS_RST}};
      fs_loaded_ff <= 1'b0;
    end
    else if (ce && !fs_loaded_ff)
    begin
      fs_ff <= factory_full_scale;
      fs_loaded_ff <= 1'b1;
    end
    else if (ce && cal.fs_we)
      fs_ff[pair] <= cal.value;
    else if (wr_evt && wr_word_ff.sel == `ADRG_SEL_FS)
      fs_ff[pair] <= wr_word_ff.data;
  end

  // Active pair toward the filter
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      act_off_ff <= `ADRG_OFFSET_RST;
      act_fs_ff <= `ADRG_FS_RST;
    end
    else if (ce)
    begin
      act_off_ff <= offset_ff[pair];
      act_fs_ff <= fs_ff[pair];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read image, frozen while a frame runs

  // Stable during frames so the link reads settled words
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      snap_ff <= '0;
    else if (ce && cs_s2_ff)
    begin
      snap_ff.result <= result_ff;
      snap_ff.status <= {ready_n_ff, status_flags, result_chan_ff};
      snap_ff.id <= {4'h0, PART_ID_NIBBLE};
      snap_ff.gpo <= gpo_read;
      snap_ff.offset <= offset_ff[pair];
      snap_ff.fs <= fs_ff[pair];
      snap_ff.append <= append_status_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ready_n = ready_n_ff;
  assign gpo_out = gpo_out_ff;
  assign gpo_oe = gpo_oe_ff;
  assign bridge_switch_ctrl = bridge_ff;
  assign active_offset = act_off_ff;
  assign active_full_scale = act_fs_ff;

endmodule // adrg_regs

// ===== adrg_regs_assertions.sv
`timescale 1ns/1ps
module adrg_regs_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic link_cs_n,
  input wire logic link_dout_oe,
  input wire adrg_pkg::adrg_conv_type conv,
  input wire logic reference_select,
  input wire adrg_pkg::adrg_cal_type cal,
  input wire logic ready_n,
  input wire logic [3:0] gpo_out,
  input wire logic [3:0] gpo_oe,
  input wire logic bridge_switch_ctrl,
  input wire logic [23:0] active_offset,
  input wire logic [23:0] active_full_scale
);
  logic [5:0] edge_cnt_ff; // Link edges seen in frame
  logic [3:0] idle_cnt_ff; // Cycles since frame closed
  logic [23:0] off_val_ff; // Last offset calibration word
  logic [23:0] fs_val_ff; // Last full-scale calibration word
  ////////////////////////////////////////////////////////////
  // Count link edges, cleared while frame closed
  always_ff @(posedge link_clk or posedge link_cs_n)
  begin
    if (link_cs_n)
      edge_cnt_ff <= 6'h00;
    else if (edge_cnt_ff != 6'h3f)
      edge_cnt_ff <= edge_cnt_ff + 6'h01;
  end
  // Count quiet cycles after a frame
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      idle_cnt_ff <= 4'hf;
    else if (!link_cs_n)
      idle_cnt_ff <= 4'h0;
    else if (idle_cnt_ff != 4'hf)
      idle_cnt_ff <= idle_cnt_ff + 4'h1;
  end
  // Hold each calibration word apart, so back-to-back pulses do not mix
  always_ff @(posedge sys_clk)
  begin
    if (ce && cal.offset_we)
      off_val_ff <= cal.value;
    if (ce && cal.fs_we)
      fs_val_ff <= cal.value;
  end
  ////////////////////////////////////////////////////////////
  sequence s_conv;
    ce && conv.valid;
  endsequence
  sequence s_ready_low;
    !ready_n;
  endsequence
  property p_ready_low;
    @(posedge sys_clk) disable iff (rst) s_conv |=> s_ready_low;
  endproperty
  a_ready_low: assert property (p_ready_low)
    else $error("ready flag not low after result");
  property p_ready_rise;
    @(posedge sys_clk) disable iff (rst) $rose(ready_n) |-> !$past(conv.valid);
  endproperty
  a_ready_rise: assert property (p_ready_rise)
    else $error("ready flag rose over a new result");
  property p_oe_pairs;
    @(posedge sys_clk) disable iff (rst) gpo_oe[3] == gpo_oe[2] && gpo_oe[1] == gpo_oe[0];
  endproperty
  a_oe_pairs: assert property (p_oe_pairs)
    else $error("pin enables split a pair");
  property p_out_masked;
    @(posedge sys_clk) disable iff (rst) (!reference_select)[*2] |-> (gpo_out & ~gpo_oe) == 4'h0;
  endproperty
  a_out_masked: assert property (p_out_masked)
    else $error("disabled pin carries a level");
  property p_ref_sel;
    @(posedge sys_clk) disable iff (rst) reference_select[*2] |-> gpo_oe[1:0] == 2'b00;
  endproperty
  a_ref_sel: assert property (p_ref_sel)
    else $error("pins 1 and 0 driven as reference");
  property p_bridge_quiet;
    @(posedge sys_clk) disable iff (rst) $changed(bridge_switch_ctrl) |-> idle_cnt_ff < 4'hc;
  endproperty
  a_bridge_quiet: assert property (p_bridge_quiet)
    else $error("bridge switch moved without host write");
  property p_cal_offset;
    @(posedge sys_clk) disable iff (rst)
      ce && cal.offset_we |-> ##[1:3] active_offset == off_val_ff;
  endproperty
  a_cal_offset: assert property (p_cal_offset)
    else $error("offset calibration not applied");
  property p_cal_fs;
    @(posedge sys_clk) disable iff (rst)
      ce && cal.fs_we |-> ##[1:3] active_full_scale == fs_val_ff;
  endproperty
  a_cal_fs: assert property (p_cal_fs)
    else $error("full-scale calibration not applied");
  property p_dout_start;
    @(posedge link_clk) disable iff (rst || link_cs_n)
      $rose(link_dout_oe) |-> edge_cnt_ff == 6'h08;
  endproperty
  a_dout_start: assert property (p_dout_start)
    else $error("read data not after command byte");
  property p_dout_window;
    @(posedge link_clk) disable iff (rst || link_cs_n)
      link_dout_oe |-> edge_cnt_ff >= 6'h08 && edge_cnt_ff <= 6'h27;
  endproperty
  a_dout_window: assert property (p_dout_window)
    else $error("read data outside its window");
endmodule // adrg_regs_chk
bind adrg_regs adrg_regs_chk i_chk (.*);

// ===== adrg_host.sv
`timescale 1ns/1ps
module adrg_host (
  output logic link_clk,
  output logic link_cs_n,
  output logic link_din,
  input wire logic link_dout
);
  // Clock stands still outside frames
  initial
  begin
    link_clk = 1'b0;
    link_cs_n = 1'b1;
    link_din = 1'b0;
  end
  // One frame: command byte then n data bits, MSB first
  task automatic xfer(input logic rd, input logic [2:0] sel, input logic [31:0] wd,
                      input int n, output logic [31:0] rdat);
    logic [7:0] cmd;
    cmd = {1'b0, rd, sel, 3'h0};
    rdat = 32'h0;
    link_cs_n = 1'b0;
    #40;
    for (int i = 0; i < 8 + n; i++)
    begin
      link_din = (i < 8) ? cmd[7 - i] : (rd ? ~link_din : wd[n + 7 - i]);
      #7.5;
      if (rd && i >= 8)
        rdat = {rdat[30:0], link_dout};
      link_clk = 1'b1;
      #7.5;
      link_clk = 1'b0;
    end
    link_cs_n = 1'b1;
    link_din = ~link_din; // Released line shows no stale level
    #60;
  endtask
endmodule // adrg_host

// ===== test_adc_result_gpo_calib_regs.sv
`timescale 1ns/1ps
module test_adc_result_gpo_calib_regs;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic link_clk, link_cs_n, link_din, link_dout, link_dout_oe;
  adrg_pkg::adrg_conv_type conv = 29'h0;
  adrg_pkg::adrg_cal_type cal = 26'h0;
  logic [2:0] status_flags = 3'h5;
  logic append_status_enable = 1'b0;
  logic pseudo_diff = 1'b0;
  logic reference_select = 1'b0;
  logic [3:0] active_channel = 4'h1;
  adrg_pkg::adrg_coef_bank_type factory_full_scale =
    {24'h500040, 24'h500030, 24'h500020, 24'h500010, 24'h500000};
  logic [3:0] gpo_pin_level = 4'h0;
  logic ready_n, bridge_switch_ctrl;
  logic [3:0] gpo_out, gpo_oe, en;
  logic [23:0] active_offset, active_full_scale;
  logic [31:0] rd;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Port writes beside pin levels
  logic [11:0] rows [6] = '{12'h305, 12'h4f0, 12'h2ec, 12'h1b3, 12'h00a, 12'h7f6};
  // Mode, channel, expected offset, expected full scale
  logic [52:0] maps [4] = '{{1'b0, 4'h5, 24'h123456, 24'h500010},
    {1'b1, 4'h5, 24'h800000, 24'h500040}, {1'b1, 4'h9, 24'h800000, 24'h500000},
    {1'b1, 4'h3, 24'h800000, 24'h500030}};
  logic [3:0] codes [4] = '{4'h0, 4'h7, 4'h8, 4'h9};
  always #5 sys_clk = ~sys_clk;
  // Identity nibble is arbitrary
  adrg_regs #(.PART_ID_NIBBLE(4'ha)) i_dut (.*);
  adrg_host i_host (.link_clk, .link_cs_n, .link_din, .link_dout);
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] probe(input int s);
    case (s)
      0: return {31'h0, ready_n};
      1: return {8'h0, active_offset};
      default: return {8'h0, active_full_scale};
    endcase
  endfunction
  // Bounded wait, then compare
  task automatic wait_for(input int s, input logic [31:0] exp);
    for (int i = 0; i < 20 && probe(s) !== exp; i++)
      @(posedge sys_clk);
    check(probe(s), exp);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({ready_n, gpo_oe, gpo_out}, 32'h100);
    i_host.xfer(1'b1, 3'h6, 32'h0, 24, rd);
    check(rd, 32'h800000);
    i_host.xfer(1'b1, 3'h7, 32'h0, 24, rd);
    check(rd, 32'h500010);
    i_host.xfer(1'b0, 3'h4, 32'hff, 8, rd);
    i_host.xfer(1'b1, 3'h4, 32'h0, 8, rd);
    check(rd, 32'h0a);
    // Port control table
    foreach (rows[i])
    begin
      @(posedge sys_clk) gpo_pin_level <= rows[i][3:0];
      i_host.xfer(1'b0, 3'h5, {24'h0, rows[i][11:4]}, 8, rd);
      en = {{2{rows[i][9]}}, {2{rows[i][8]}}};
      check({gpo_oe, gpo_out}, {en, rows[i][7:4] & en});
      check(bridge_switch_ctrl, rows[i][10]);
      i_host.xfer(1'b1, 3'h5, 32'h0, 8, rd);
      check(rd & {4'hf, en}, {rows[i][11:8], rows[i][3:0] & en});
    end
    @(posedge sys_clk) reference_select <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(gpo_oe, 32'hc);
    reference_select <= 1'b0;
    // New result, ignored write, then read
    @(posedge sys_clk) conv <= '{1'b1, 24'habcdef, 4'h6};
    @(posedge sys_clk) conv.valid <= 1'b0;
    wait_for(0, 32'h0);
    i_host.xfer(1'b0, 3'h3, 32'h123456, 24, rd);
    check(ready_n, 32'h0);
    i_host.xfer(1'b1, 3'h3, 32'h0, 24, rd);
    check(rd, 32'habcdef);
    wait_for(0, 32'h1);
    // Frozen clock enable ignores a new result
    @(posedge sys_clk) ce <= 1'b0;
    conv <= '{1'b1, 24'h000000, 4'h0};
    @(posedge sys_clk) conv.valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(ready_n, 32'h1);
    ce <= 1'b1;
    // Appended status with channel codes 0, 7, 8 and 9
    append_status_enable <= 1'b1;
    foreach (codes[i])
    begin
      @(posedge sys_clk) conv <= '{1'b1, {20'h12345, codes[i]}, codes[i]};
      @(posedge sys_clk) conv.valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
      i_host.xfer(1'b1, 3'h3, 32'h0, 32, rd);
      check(rd, {20'h12345, codes[i], 4'h5, codes[i]});
    end
    // Converter idle here before coefficient writes
    i_host.xfer(1'b0, 3'h6, 32'h123456, 24, rd);
    wait_for(1, 32'h123456);
    foreach (maps[i])
    begin
      @(posedge sys_clk) {pseudo_diff, active_channel} <= maps[i][52:48];
      wait_for(1, maps[i][47:24]);
      wait_for(2, maps[i][23:0]);
    end
    @(posedge sys_clk) cal <= '{1'b1, 1'b0, 24'h0badc0};
    @(posedge sys_clk) cal <= '{1'b0, 1'b1, 24'h654321};
    @(posedge sys_clk) cal <= 26'h0;
    wait_for(1, 32'h0badc0);
    wait_for(2, 32'h654321);
    i_host.xfer(1'b0, 3'h7, 32'h777777, 24, rd);
    wait_for(2, 32'h777777);
    i_host.xfer(1'b1, 3'h7, 32'h0, 24, rd);
    check(rd, 32'h777777);
    // Second reset in mid-run
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check({ready_n, gpo_oe, active_offset}, 32'h10800000);
    rst <= 1'b0;
    wait_for(2, 32'h500030);
    test_done;
  end
endmodule // test_adc_result_gpo_calib_regs
